// File: rtl/abx_pkg.sv
// constants, register map and types for the add and bit-operation execute block
package abx_pkg;
  localparam int ABX_ADDR_W = 12;
  localparam int ABX_DATA_W = 32;
  localparam logic [11:0] ABX_REG_CMD = 12'h000;
  localparam logic [11:0] ABX_REG_ACC = 12'h004;
  localparam logic [11:0] ABX_REG_STATUS = 12'h008;
  localparam logic [11:0] ABX_REG_CTRL = 12'h00C;
  localparam logic [11:0] ABX_FILE_BASE = 12'h400;
  localparam logic [11:0] ABX_FILE_END = 12'h5FC;
  // command word fields
  localparam int ABX_CMD_OP_LSB = 0;
  localparam int ABX_CMD_DEST_BIT = 3;
  localparam int ABX_CMD_BIT_LSB = 4;
  localparam int ABX_CMD_FILE_LSB = 7;
  localparam int ABX_CMD_LIT_LSB = 16;
  // status and control word fields
  localparam int ABX_ST_CARRY = 0;
  localparam int ABX_ST_NIBBLE = 1;
  localparam int ABX_ST_ZERO = 2;
  localparam int ABX_ST_BUSY = 3;
  localparam int ABX_ST_SKIP = 4;
  localparam int ABX_CTRL_PRESC_ASSIGNED = 0;
  // reset values
  localparam logic [7:0] ABX_ACC_RESET = 8'h00;
  localparam logic [2:0] ABX_FLAGS_RESET = 3'h0;
  localparam logic [31:0] ABX_CMD_RESET = 32'h0000_0007;
  // file addresses of the special registers
  localparam logic [6:0] ABX_PORT_FILE = 7'h05;
  localparam logic [6:0] ABX_TIMER_FILE = 7'h01;
  localparam logic [1:0] ABX_RESP_OKAY = 2'h0;
  localparam logic [1:0] ABX_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ABX_OP_ADD_IMM = 3'h0, // add_immediate_to_acc
    ABX_OP_ADD_FILE = 3'h1, // add_acc_with_file
    ABX_OP_AND_IMM = 3'h2, // and_immediate_to_acc
    ABX_OP_AND_FILE = 3'h3, // and_acc_with_file
    ABX_OP_BIT_LOW = 3'h4, // file_bit_force_low
    ABX_OP_BIT_HIGH = 3'h5, // file_bit_force_high
    ABX_OP_SKIP_LOW = 3'h6, // skip_when_bit_low
    ABX_OP_NONE = 3'h7
  } abx_op_type;

  typedef enum logic [2:0] {
    ABX_ST_IDLE = 3'b001,
    ABX_ST_EXEC = 3'b010,
    ABX_ST_NOP = 3'b100
  } abx_state_type;
endpackage

// File: rtl/abx_execute.sv
// add, and, bit-force and bit-test execute unit with an AXI4-Lite register slave
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module abx_execute (
  input wire logic clock, // 40 MHz instruction clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [abx_pkg::ABX_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [abx_pkg::ABX_DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [abx_pkg::ABX_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [abx_pkg::ABX_DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [7:0] portPins, // port pin levels, asynchronous
  output logic [7:0] portLatch, // port output latch
  output logic prescalerClear, // one-cycle pulse clearing the timer prescaler
  output logic skipTaken // one-cycle pulse during the discarded slot
);
  import abx_pkg::*;

  // merge byte lanes of a bus write into an old word
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
      begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction

  logic [7:0] fileMem [0:127];
  logic [7:0] pinMeta, pinSync;
  abx_state_type state, next_state;
  logic [31:0] cmd, next_cmd;
  logic [7:0] acc, next_acc;
  logic [2:0] flags, next_flags;
  logic presAssigned, next_presAssigned;
  logic lastSkip, next_lastSkip;
  logic awHeld, next_awHeld, wHeld, next_wHeld;
  logic [11:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic next_prescalerClear, next_skipTaken;
  logic fileWe;
  logic [6:0] fileWa;
  logic [7:0] fileWd;
  abx_op_type op;
  logic [6:0] fAddr;
  logic [2:0] bitSel;
  logic dest;
  logic [7:0] lit, opd, res;
  logic [8:0] sum;
  logic [4:0] nib;
  logic busWrite;
  logic fileHit;
  logic [6:0] fileIdx;

  // pins cross in through two flops; only the second is read
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinMeta <= 8'h00;
      pinSync <= 8'h00;
    end
    else
    begin
      pinMeta <= portPins;
      pinSync <= pinMeta;
    end
  end

  // command decode and datapath
  always_comb
  begin
    op = abx_op_type'(cmd[ABX_CMD_OP_LSB +: 3]);
    dest = cmd[ABX_CMD_DEST_BIT];
    bitSel = cmd[ABX_CMD_BIT_LSB +: 3];
    fAddr = cmd[ABX_CMD_FILE_LSB +: 7];
    lit = cmd[ABX_CMD_LIT_LSB +: 8];
    opd = (fAddr == ABX_PORT_FILE) ? pinSync : fileMem[fAddr];
    if (op == ABX_OP_ADD_IMM || op == ABX_OP_AND_IMM)
    begin
      opd = lit;
    end
    sum = {1'b0, acc} + {1'b0, opd};
    nib = {1'b0, acc[3:0]} + {1'b0, opd[3:0]};
    res = acc & opd;
  end

  // bus write decode for the file window
  always_comb
  begin
    fileHit = (awAddr >= ABX_FILE_BASE) && (awAddr <= ABX_FILE_END);
    fileIdx = 7'(awAddr[8:2]);
    busWrite = awHeld && wHeld && !s_axi_bvalid && (state == ABX_ST_IDLE);
  end

  // control, execution and bus slave next state
  always_comb
  begin
    next_state = state;
    next_cmd = cmd;
    next_acc = acc;
    next_flags = flags;
    next_presAssigned = presAssigned;
    next_lastSkip = lastSkip;
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_prescalerClear = 1'b0;
    next_skipTaken = 1'b0;
    fileWe = 1'b0;
    fileWa = fAddr;
    fileWd = opd;
    case (state)
      ABX_ST_EXEC:
      begin
        next_state = ABX_ST_IDLE;
        case (op)
          ABX_OP_ADD_IMM, ABX_OP_ADD_FILE:
          begin
            fileWd = sum[7:0];
            fileWe = (op == ABX_OP_ADD_FILE) && dest;
            if (!fileWe)
            begin
              next_acc = sum[7:0];
            end
            next_flags[ABX_ST_CARRY] = sum[8];
            next_flags[ABX_ST_NIBBLE] = nib[4];
            next_flags[ABX_ST_ZERO] = (sum[7:0] == 8'h00);
          end
          ABX_OP_AND_IMM, ABX_OP_AND_FILE:
          begin
            fileWd = res;
            fileWe = (op == ABX_OP_AND_FILE) && dest;
            if (!fileWe)
            begin
              next_acc = res;
            end
            next_flags[ABX_ST_ZERO] = (res == 8'h00);
          end
          ABX_OP_BIT_LOW:
          begin
            fileWe = 1'b1;
            fileWd[bitSel] = 1'b0;
          end
          ABX_OP_BIT_HIGH:
          begin
            fileWe = 1'b1;
            fileWd[bitSel] = 1'b1;
          end
          ABX_OP_SKIP_LOW:
          begin
            // flags stay; a clear bit costs a second, empty cycle
            next_lastSkip = !opd[bitSel];
            if (!opd[bitSel])
            begin
              next_state = ABX_ST_NOP;
              next_skipTaken = 1'b1;
            end
          end
          default:
          begin
            next_state = ABX_ST_IDLE;
          end
        endcase
        next_prescalerClear = fileWe && (fAddr == ABX_TIMER_FILE) && presAssigned;
      end
      ABX_ST_NOP:
      begin
        next_state = ABX_ST_IDLE;
      end
      default:
      begin
        next_state = ABX_ST_IDLE;
      end
    endcase
    // capture address and data independently
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    // writes wait for an idle core so bus and instruction never collide
    if (busWrite)
    begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = ABX_RESP_OKAY;
      if (fileHit)
      begin
        fileWe = wStrb[0];
        fileWa = fileIdx;
        fileWd = wData[7:0];
      end
      else
      begin
        case (awAddr)
          ABX_REG_CMD:
          begin
            next_cmd = strb_merge(cmd, wData, wStrb);
            next_state = ABX_ST_EXEC;
            next_lastSkip = 1'b0;
          end
          ABX_REG_ACC: next_acc = wStrb[0] ? wData[7:0] : acc;
          ABX_REG_STATUS: next_flags = wStrb[0] ? wData[2:0] : flags;
          ABX_REG_CTRL: next_presAssigned = wStrb[0] ? wData[0] : presAssigned;
          default: next_bresp = ABX_RESP_SLVERR;
        endcase
      end
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_awHeld && !next_bvalid;
    next_wready = !next_wHeld && !next_bvalid;
    // read path answers one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = ABX_RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if ((s_axi_araddr >= ABX_FILE_BASE) && (s_axi_araddr <= ABX_FILE_END))
      begin
        next_rdata[7:0] = fileMem[7'(s_axi_araddr[8:2])];
      end
      else
      begin
        case (s_axi_araddr)
          ABX_REG_CMD: next_rdata = cmd;
          ABX_REG_ACC: next_rdata[7:0] = acc;
          ABX_REG_STATUS: next_rdata[4:0] = {lastSkip, state != ABX_ST_IDLE, flags};
          ABX_REG_CTRL: next_rdata[0] = presAssigned;
          default: next_rresp = ABX_RESP_SLVERR;
        endcase
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    next_arready = !next_rvalid;
  end

  // register control, datapath and bus slave state
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ABX_ST_IDLE;
      cmd <= ABX_CMD_RESET;
      acc <= ABX_ACC_RESET;
      flags <= ABX_FLAGS_RESET;
      presAssigned <= 1'b0;
      lastSkip <= 1'b0;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 12'h000;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
      prescalerClear <= 1'b0;
      skipTaken <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cmd <= next_cmd;
      acc <= next_acc;
      flags <= next_flags;
      presAssigned <= next_presAssigned;
      lastSkip <= next_lastSkip;
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddr <= next_awAddr;
      wData <= next_wData;
      wStrb <= next_wStrb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      prescalerClear <= next_prescalerClear;
      skipTaken <= next_skipTaken;
    end
  end

  // file memory has no reset; contents are undefined until written
  always_ff @(posedge clock)
  begin
    if (fileWe)
    begin
      fileMem[fileWa] <= fileWd;
    end
  end

  // port latch mirrors the port file register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      portLatch <= 8'h00;
    end
    else if (fileWe && fileWa == ABX_PORT_FILE)
    begin
      portLatch <= fileWd;
    end
  end
endmodule // abx_execute

// File: testbench/abx_execute_checker.sv
// bus handshake and pulse-width checks on the execute block's ports
`timescale 1ns/10ps
module abx_execute_checker (
  input wire logic clock, // clock
  input wire logic rst_n, // reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic prescalerClear, // prescaler pulse
  input wire logic skipTaken // skip pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // a request is taken only when both halves of the handshake meet
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_read_answer;
    s_ar_take |=> s_axi_rvalid;
  endproperty
  property p_write_answer;
    s_w_take |-> ##[1:4] s_axi_bvalid;
  endproperty
  property p_read_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_write_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_aw_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_skip_pulse;
    skipTaken |=> !skipTaken;
  endproperty
  property p_presc_pulse;
    prescalerClear |=> !prescalerClear;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  a_write_answer: assert property (p_write_answer) else $error("write late");
  a_read_hold: assert property (p_read_hold) else $error("read data dropped");
  a_write_hold: assert property (p_write_hold) else $error("write response dropped");
  a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
  a_aw_refuse: assert property (p_aw_refuse) else $error("write taken while busy");
  a_skip_pulse: assert property (p_skip_pulse) else $error("skip pulse too long");
  a_presc_pulse: assert property (p_presc_pulse) else $error("clear pulse too long");
endmodule // abx_execute_checker

bind abx_execute abx_execute_checker u_chk (
  .clock(clock),
  .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .prescalerClear(prescalerClear),
  .skipTaken(skipTaken)
);

// File: testbench/abx_execute_test.sv
// register-level testbench for the execute block
`timescale 1ns/10ps
module abx_execute_test;
  import abx_pkg::*;
  logic clock = 0, rst_n = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, skipTaken, prescalerClear;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] portPins = 8'hA5, portLatch;
  int nMismatch = 0, testsRun = 0, nSkip = 0, nClr = 0;
  abx_execute u_dut (
    .clock(clock),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .portPins(portPins),
    .portLatch(portLatch),
    .prescalerClear(prescalerClear),
    .skipTaken(skipTaken)
  );
  initial forever #12.5 clock = ~clock;
  // count one-cycle pulses so a scenario can compare totals
  always @(posedge clock)
  begin
    if (skipTaken === 1'b1) nSkip++;
    if (prescalerClear === 1'b1) nClr++;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // each channel drops its valid at the edge where ready was seen
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    while (1)
    begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rdReg(input logic [11:0] a);
    @(posedge clock);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    while (1)
    begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // the instruction settles within two edges of the command write
  task ex(input abx_op_type op, input logic d, input logic [2:0] b, input logic [6:0] f,
          input logic [7:0] k);
    wr(ABX_REG_CMD, {8'h00, k, 2'b00, f, b, d, op});
    repeat (3) @(posedge clock);
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rdReg(ABX_REG_CMD); chk(rd, ABX_CMD_RESET);
    rdReg(ABX_REG_STATUS); chk(rd, 32'h0);
    $display("reset test done");
    wr(ABX_REG_ACC, 32'h88);
    ex(ABX_OP_ADD_IMM, 0, 0, 0, 8'h88);
    rdReg(ABX_REG_ACC); chk(rd, 32'h10);
    rdReg(ABX_REG_STATUS); chk(rd, 32'h3);
    ex(ABX_OP_ADD_IMM, 0, 0, 0, 8'hF0);
    rdReg(ABX_REG_STATUS); chk(rd, 32'h5);
    wr(ABX_REG_STATUS, 32'h3);
    wr(ABX_REG_ACC, 32'h0F);
    ex(ABX_OP_AND_IMM, 0, 0, 0, 8'hF0);
    rdReg(ABX_REG_ACC); chk(rd, 32'h0);
    rdReg(ABX_REG_STATUS); chk(rd, 32'h7);
    $display("immediate test done");
    wr(ABX_FILE_BASE + 12'h00C, 32'h0F);
    wr(ABX_REG_ACC, 32'h01);
    wr(ABX_REG_STATUS, 32'h0);
    ex(ABX_OP_ADD_FILE, 1, 0, 7'h03, 0);
    rdReg(ABX_FILE_BASE + 12'h00C); chk(rd, 32'h10);
    rdReg(ABX_REG_ACC); chk(rd, 32'h01);
    rdReg(ABX_REG_STATUS); chk(rd, 32'h2);
    ex(ABX_OP_AND_FILE, 0, 0, 7'h03, 0);
    rdReg(ABX_REG_ACC); chk(rd, 32'h0);
    rdReg(ABX_FILE_BASE + 12'h00C); chk(rd, 32'h10);
    rdReg(ABX_REG_STATUS); chk(rd, 32'h6);
    $display("file test done");
    ex(ABX_OP_BIT_HIGH, 0, 3'h7, 7'h03, 0);
    rdReg(ABX_FILE_BASE + 12'h00C); chk(rd, 32'h90);
    ex(ABX_OP_BIT_LOW, 0, 3'h4, 7'h03, 0);
    rdReg(ABX_FILE_BASE + 12'h00C); chk(rd, 32'h80);
    rdReg(ABX_REG_STATUS); chk(rd, 32'h6);
    ex(ABX_OP_SKIP_LOW, 0, 3'h0, 7'h03, 0);
    rdReg(ABX_REG_STATUS); chk(rd, 32'h16);
    chk(nSkip, 1);
    ex(ABX_OP_SKIP_LOW, 0, 3'h7, 7'h03, 0);
    rdReg(ABX_REG_STATUS); chk(rd, 32'h6);
    chk(nSkip, 1);
    $display("bit test done");
    wr(ABX_REG_CTRL, 32'h1);
    ex(ABX_OP_BIT_HIGH, 0, 3'h0, ABX_TIMER_FILE, 0);
    chk(nClr, 1);
    wr(ABX_REG_CTRL, 32'h0);
    ex(ABX_OP_BIT_LOW, 0, 3'h0, ABX_TIMER_FILE, 0);
    chk(nClr, 1);
    ex(ABX_OP_BIT_HIGH, 0, 3'h1, ABX_PORT_FILE, 0);
    chk(portLatch, 8'hA7);
    // new pin levels differ from the latch, so a latch read would give A3
    portPins <= 8'h3C;
    ex(ABX_OP_BIT_LOW, 0, 3'h2, ABX_PORT_FILE, 0);
    chk(portLatch, 8'h38);
    // the other destination of each file operation
    wr(ABX_FILE_BASE + 12'h008, 32'h3C);
    wr(ABX_REG_ACC, 32'h0F);
    ex(ABX_OP_AND_FILE, 1, 0, 7'h02, 0);
    rdReg(ABX_FILE_BASE + 12'h008); chk(rd, 32'h0C);
    rdReg(ABX_REG_ACC); chk(rd, 32'h0F);
    ex(ABX_OP_ADD_FILE, 0, 0, 7'h02, 0);
    rdReg(ABX_REG_ACC); chk(rd, 32'h1B);
    rdReg(ABX_FILE_BASE + 12'h008); chk(rd, 32'h0C);
    rdReg(ABX_REG_STATUS); chk(rd, 32'h2);
    rdReg(12'h010); chk(rsp, ABX_RESP_SLVERR);
    chk(rd, 32'h0);
    wr(12'h020, 32'h1); chk(rsp, ABX_RESP_SLVERR);
    $display("side effect test done");
    conclude;
  end
  // a hung handshake ends the run through the same verdict
  initial
  begin
    repeat (20000) @(posedge clock);
    nMismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude;
  end
endmodule // abx_execute_test
